// ### rtl/rir_cfg.svh
// offsets, field positions, encodings and cycle counts of the return instruction unit
`ifndef RIR_CFG_SVH
`define RIR_CFG_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define RIR_OFS_STATUS   8'h00
`define RIR_OFS_PC       8'h04
`define RIR_OFS_SP       8'h08
`define RIR_OFS_FLAGS    8'h0C

// ----------------------------------------
// status fields (read) and command bits (write)
// ----------------------------------------
`define RIR_ST_ACTIVE    0
`define RIR_ST_SAVED     1
`define RIR_ST_BUSY      2
`define RIR_ST_UNSUP     3
`define RIR_ST_NMI_PEND  4
`define RIR_WR_EI        0
`define RIR_WR_DI        1
`define RIR_WR_CLR_UNSUP 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RIR_RST_PC       16'h0000
`define RIR_RST_SP       16'h0000
`define RIR_RST_FLAGS    8'h00

// ----------------------------------------
// opcode encodings
// ----------------------------------------
`define RIR_OP_PREFIX    8'hED
`define RIR_OP_MEXIT     8'h4D
`define RIR_OP_NEXIT     8'h45
`define RIR_RETCC_TOP    2'h3
`define RIR_RETCC_LOW    3'h0
`define RIR_NMI_VECTOR   16'h0066
`define RIR_CC_NZ        3'h0
`define RIR_CC_Z         3'h1
`define RIR_CC_NC        3'h2
`define RIR_CC_C         3'h3
`define RIR_CC_PO        3'h4
`define RIR_CC_PE        3'h5
`define RIR_CC_P         3'h6
`define RIR_CC_M         3'h7

// ----------------------------------------
// clock states per instruction (one state = one clock)
// ----------------------------------------
`define RIR_T_RETCC_TAKEN 4'hB
`define RIR_T_RETCC_SKIP  4'h5
`define RIR_T_SVC_EXIT    4'hE
`define RIR_T_NMI         4'hB
`define RIR_T_UNSUP       4'h4
`define RIR_T_POP_RETCC   4'h5
`define RIR_T_POP_SVC     4'h8
`define RIR_T_PUSH_NMI    4'h5
`define RIR_T_BYTE_GAP    4'h3

`endif

// ### rtl/rir_pkg.sv
// types shared by the return instruction unit
package rir_pkg;

	typedef struct packed {
		logic sign;
		logic zero;
		logic bit5;
		logic half;
		logic bit3;
		logic parity;
		logic subtract;
		logic carry;
	} rir_flags_t;

	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} rir_op_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} rir_mem_req_t;

	typedef enum logic {RIR_IDLE, RIR_RUN} rir_state_t;

	typedef enum logic [2:0] {K_RETCC, K_SKIP, K_MEXIT, K_NEXIT, K_NMI, K_UNSUP} rir_kind_t;

endpackage : rir_pkg

// ### rtl/rir_cond_eval.sv
// condition field decoder for the conditional return
`timescale 1ns/1ns
`default_nettype none
`include "rir_cfg.svh"

module rir_cond_eval import rir_pkg::*; (
	input  wire logic [2:0] i_cc,
	input  wire rir_flags_t i_flags,
	output logic            o_true
);

	always_comb begin
		unique case (i_cc)
			`RIR_CC_NZ: o_true = !i_flags.zero;
			`RIR_CC_Z:  o_true = i_flags.zero;
			`RIR_CC_NC: o_true = !i_flags.carry;
			`RIR_CC_C:  o_true = i_flags.carry;
			`RIR_CC_PO: o_true = !i_flags.parity;
			`RIR_CC_PE: o_true = i_flags.parity;
			`RIR_CC_P:  o_true = !i_flags.sign;
			`RIR_CC_M:  o_true = i_flags.sign;
		endcase
	end

endmodule : rir_cond_eval
`default_nettype wire

// ### rtl/rir_apb_slave.sv
// apb slave front end: one wait state, registered answer
`timescale 1ns/1ns
`default_nettype none
`include "rir_cfg.svh"

module rir_apb_slave import rir_pkg::*; (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_rdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	output logic             o_wr_stb
);

	logic        hit;
	logic        first_access;
	logic        next_pready;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	always_comb begin
		hit = (i_paddr == `RIR_OFS_STATUS) || (i_paddr == `RIR_OFS_PC) ||
			(i_paddr == `RIR_OFS_SP) || (i_paddr == `RIR_OFS_FLAGS);
		first_access = i_psel && i_penable && !o_pready;
		next_pready  = first_access;
		next_pslverr = first_access && !hit;
		next_prdata  = (first_access && hit && !i_pwrite) ? i_rdata : 32'h0;
		// write lands on the edge that samples pready high
		o_wr_stb = i_psel && i_penable && o_pready && i_pwrite && hit;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= next_pready;
			o_prdata  <= next_prdata;
			o_pslverr <= next_pslverr;
		end
	end

endmodule : rir_apb_slave
`default_nettype wire

// ### rtl/rir_core.sv
// return instruction unit: conditional return, service exits and nmi entry
`timescale 1ns/1ns
`default_nettype none
`include "rir_cfg.svh"

// Behaviour
// - A taken return reads the low pc byte at the stack pointer, steps it, reads the high byte, steps it again.
// - A conditional return whose condition fails touches no stack and only advances the pc by one.
// - The three-bit condition selects not-zero, zero, no-carry, carry, parity odd/even, sign plus/minus.
// - The ED 4D maskable service exit restores the pc from the stack like a plain return.
// - The maskable service exit is made visible to the peripherals as the end of their service.
// - The maskable service exit leaves the active interrupt enable as it is.
// - The ED 45 non-maskable service exit restores the pc from the stack like a plain return.
// - The non-maskable service exit copies the saved enable into the active enable.
// - A non-maskable request holds off the next instruction without advancing the pc, pushes the pc and restarts at 0066H.
// - The nmi push writes the high byte at sp-1 and the low byte at sp-2, leaving sp two lower.
// - Every taken return pops low then high and leaves sp where it stood before the matching push.
// - None of the three returns alters any flag bit.
module rir_core import rir_pkg::*; (
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	input  wire logic         i_psel,
	input  wire logic         i_penable,
	input  wire logic         i_pwrite,
	input  wire logic [7:0]   i_paddr,
	input  wire logic [31:0]  i_pwdata,
	output logic              o_pready,
	output logic [31:0]       o_prdata,
	output logic              o_pslverr,
	input  wire logic         i_op_valid,
	input  wire rir_op_t      i_op,
	output logic              o_op_ready,
	input  wire logic         i_nmi,
	output var rir_mem_req_t  o_mem,
	input  wire logic [7:0]   i_mem_rdata,
	output logic              o_service_exit,
	output logic [15:0]       o_pc,
	output logic              o_active_irq_enable
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	rir_state_t   state,              next_state;
	rir_kind_t    kind,               next_kind;
	logic [3:0]   tcnt,               next_tcnt;
	logic [15:0]  program_counter,    next_program_counter;
	logic [15:0]  stack_pointer,      next_stack_pointer;
	rir_flags_t   flags,              next_flags;
	logic         active_irq_enable,  next_active_irq_enable;
	logic         saved_irq_enable,   next_saved_irq_enable;
	logic [7:0]   pop_lo,             next_pop_lo;
	logic         unsup,              next_unsup;
	logic         nmi_pend,           next_nmi_pend;
	rir_mem_req_t next_mem;
	logic         next_service_exit;
	logic         next_op_ready;

	logic         wr_stb;
	logic [31:0]  rd_data;
	logic         cond_true;
	logic         accept;
	logic         is_retcc;
	logic         is_ext;
	logic [3:0]   t_a;
	logic [3:0]   t_b;
	logic [3:0]   t_len;

	// ----------------------------------------
	// per-kind timing
	// ----------------------------------------
	function automatic logic [3:0] kind_len(input rir_kind_t k);
		unique case (k)
			K_RETCC:  kind_len = `RIR_T_RETCC_TAKEN;
			K_SKIP:   kind_len = `RIR_T_RETCC_SKIP;
			K_MEXIT:  kind_len = `RIR_T_SVC_EXIT;
			K_NEXIT:  kind_len = `RIR_T_SVC_EXIT;
			K_NMI:    kind_len = `RIR_T_NMI;
			K_UNSUP:  kind_len = `RIR_T_UNSUP;
			default:  kind_len = `RIR_T_UNSUP;
		endcase
	endfunction : kind_len

	function automatic logic [3:0] kind_issue(input rir_kind_t k);
		unique case (k)
			K_RETCC:  kind_issue = `RIR_T_POP_RETCC;
			K_MEXIT:  kind_issue = `RIR_T_POP_SVC;
			K_NEXIT:  kind_issue = `RIR_T_POP_SVC;
			K_NMI:    kind_issue = `RIR_T_PUSH_NMI;
			default:  kind_issue = 4'hF;
		endcase
	endfunction : kind_issue

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	rir_apb_slave u_apb (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_paddr   (i_paddr),
		.i_rdata   (rd_data),
		.o_pready  (o_pready),
		.o_prdata  (o_prdata),
		.o_pslverr (o_pslverr),
		.o_wr_stb  (wr_stb)
	);

	rir_cond_eval u_cond (
		.i_cc    (i_op.first[5:3]),
		.i_flags (flags),
		.o_true  (cond_true)
	);

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	always_comb begin
		rd_data = 32'h0;
		case (i_paddr)
			`RIR_OFS_STATUS: begin
				rd_data[`RIR_ST_ACTIVE]   = active_irq_enable;
				rd_data[`RIR_ST_SAVED]    = saved_irq_enable;
				rd_data[`RIR_ST_BUSY]     = (state == RIR_RUN);
				rd_data[`RIR_ST_UNSUP]    = unsup;
				rd_data[`RIR_ST_NMI_PEND] = nmi_pend;
			end
			`RIR_OFS_PC:    rd_data[15:0] = program_counter;
			`RIR_OFS_SP:    rd_data[15:0] = stack_pointer;
			`RIR_OFS_FLAGS: rd_data[7:0]  = flags;
			default:        rd_data = 32'h0;
		endcase
	end

	// ----------------------------------------
	// sequencer next state
	// ----------------------------------------
	always_comb begin
		is_ext   = (i_op.first == `RIR_OP_PREFIX);
		is_retcc = (i_op.first[7:6] == `RIR_RETCC_TOP) &&
			(i_op.first[2:0] == `RIR_RETCC_LOW);
		accept   = (state == RIR_IDLE) && !nmi_pend && i_op_valid && o_op_ready;
		t_a      = kind_issue(kind);
		t_b      = t_a + `RIR_T_BYTE_GAP;
		t_len    = kind_len(kind);

		next_state             = state;
		next_kind              = kind;
		next_tcnt              = tcnt;
		next_program_counter   = program_counter;
		next_stack_pointer     = stack_pointer;
		next_flags             = flags;
		next_active_irq_enable = active_irq_enable;
		next_saved_irq_enable  = saved_irq_enable;
		next_pop_lo            = pop_lo;
		next_unsup             = unsup;
		next_nmi_pend          = nmi_pend || i_nmi;
		next_mem               = '0;
		next_service_exit      = 1'b0;

		// software writes take effect only while idle, so a running instruction sees stable state
		if (wr_stb && state == RIR_IDLE) begin
			if (i_paddr == `RIR_OFS_STATUS) begin
				if (i_pwdata[`RIR_WR_EI]) begin
					next_active_irq_enable = 1'b1;
					next_saved_irq_enable  = 1'b1;
				end else if (i_pwdata[`RIR_WR_DI]) begin
					next_active_irq_enable = 1'b0;
					next_saved_irq_enable  = 1'b0;
				end
				if (i_pwdata[`RIR_WR_CLR_UNSUP])
					next_unsup = 1'b0;
			end else if (i_paddr == `RIR_OFS_PC) begin
				next_program_counter = i_pwdata[15:0];
			end else if (i_paddr == `RIR_OFS_SP) begin
				next_stack_pointer = i_pwdata[15:0];
			end else if (i_paddr == `RIR_OFS_FLAGS) begin
				next_flags = i_pwdata[7:0];
			end
		end

		unique case (state)
			RIR_IDLE: begin
				next_tcnt = 4'h1;
				if (nmi_pend) begin
					// the pending instruction is not taken
					next_state             = RIR_RUN;
					next_kind              = K_NMI;
					next_tcnt              = 4'h2;
					next_saved_irq_enable  = active_irq_enable;
					next_active_irq_enable = 1'b0;
					next_nmi_pend          = i_nmi;
				end else if (accept) begin
					next_state = RIR_RUN;
					next_tcnt  = 4'h2;
					if (!is_ext && is_retcc) begin
						next_kind = cond_true ? K_RETCC : K_SKIP;
					end else if (is_ext && i_op.second == `RIR_OP_MEXIT) begin
						next_kind = K_MEXIT;
					end else if (is_ext && i_op.second == `RIR_OP_NEXIT) begin
						next_kind = K_NEXIT;
					end else begin
						next_kind  = K_UNSUP;
						next_unsup = 1'b1;
						next_program_counter = program_counter + (is_ext ? 16'h2 : 16'h1);
					end
				end
			end
			RIR_RUN: begin
				next_tcnt = tcnt + 4'h1;
				if (kind == K_RETCC || kind == K_MEXIT || kind == K_NEXIT) begin
					if (tcnt == t_a - 4'h1 || tcnt == t_b - 4'h1) begin
						next_mem.rd   = 1'b1;
						next_mem.addr = stack_pointer;
					end
					if (tcnt == t_a + 4'h1) begin
						next_pop_lo        = i_mem_rdata;
						next_stack_pointer = stack_pointer + 16'h1;
					end
					if (tcnt == t_b + 4'h1) begin
						next_program_counter = {i_mem_rdata, pop_lo};
						next_stack_pointer   = stack_pointer + 16'h1;
					end
				end
				if (kind == K_NMI) begin
					if (tcnt == t_a - 4'h1) begin
						next_mem.wr        = 1'b1;
						next_mem.addr      = stack_pointer - 16'h1;
						next_mem.wdata     = program_counter[15:8];
						next_stack_pointer = stack_pointer - 16'h1;
					end
					if (tcnt == t_b - 4'h1) begin
						next_mem.wr        = 1'b1;
						next_mem.addr      = stack_pointer - 16'h1;
						next_mem.wdata     = program_counter[7:0];
						next_stack_pointer = stack_pointer - 16'h1;
					end
				end
				if (tcnt == t_len) begin
					next_state = RIR_IDLE;
					next_tcnt  = 4'h1;
					if (kind == K_SKIP)
						next_program_counter = program_counter + 16'h1;
					if (kind == K_MEXIT)
						next_service_exit = 1'b1;
					if (kind == K_NEXIT)
						next_active_irq_enable = saved_irq_enable;
					if (kind == K_NMI)
						next_program_counter = `RIR_NMI_VECTOR;
				end
			end
		endcase

		next_op_ready = (next_state == RIR_IDLE) && !next_nmi_pend;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state             <= RIR_IDLE;
			kind              <= K_SKIP;
			tcnt              <= 4'h1;
			program_counter   <= `RIR_RST_PC;
			stack_pointer     <= `RIR_RST_SP;
			flags             <= `RIR_RST_FLAGS;
			active_irq_enable <= 1'b0;
			saved_irq_enable  <= 1'b0;
			pop_lo            <= 8'h00;
			unsup             <= 1'b0;
			nmi_pend          <= 1'b0;
			o_mem             <= '0;
			o_service_exit    <= 1'b0;
			o_op_ready        <= 1'b0;
		end else begin
			state             <= next_state;
			kind              <= next_kind;
			tcnt              <= next_tcnt;
			program_counter   <= next_program_counter;
			stack_pointer     <= next_stack_pointer;
			flags             <= next_flags;
			active_irq_enable <= next_active_irq_enable;
			saved_irq_enable  <= next_saved_irq_enable;
			pop_lo            <= next_pop_lo;
			unsup             <= next_unsup;
			nmi_pend          <= next_nmi_pend;
			o_mem             <= next_mem;
			o_service_exit    <= next_service_exit;
			o_op_ready        <= next_op_ready;
		end
	end

	always_comb begin
		o_pc                = program_counter;
		o_active_irq_enable = active_irq_enable;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [15:0] entry_sp;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn)
			entry_sp <= 16'h0;
		else if (state == RIR_RUN && tcnt == 4'h2)
			entry_sp <= stack_pointer;
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	property p_pop_at_sp;
		o_mem.rd |-> (o_mem.addr == stack_pointer);
	endproperty
	a_pop_at_sp: assert property (p_pop_at_sp) else $error("pop not at stack pointer");

	property p_pop_order;
		(o_mem.rd && tcnt == t_a) |-> ##3 (o_mem.rd && o_mem.addr == $past(o_mem.addr, 3) + 16'h1);
	endproperty
	a_pop_order: assert property (p_pop_order) else $error("high byte not read at next address");

	property p_skip_quiet;
		(state == RIR_RUN && kind == K_SKIP) |-> (!o_mem.rd && !o_mem.wr && $stable(stack_pointer));
	endproperty
	a_skip_quiet: assert property (p_skip_quiet) else $error("skipped return touched stack");

	property p_cc_carry;
		(accept && !is_ext && is_retcc && i_op.first[5:3] == 3'h3) |=>
			((kind == K_RETCC) == $past(flags.carry));
	endproperty
	a_cc_carry: assert property (p_cc_carry) else $error("carry condition misdecoded");

	property p_mexit_keeps_enable;
		(state == RIR_RUN && kind == K_MEXIT) |=> $stable(active_irq_enable);
	endproperty
	a_mexit_keeps_enable: assert property (p_mexit_keeps_enable) else $error("enable changed");

	property p_mexit_signal;
		(accept && is_ext && i_op.second == 8'h4D) |-> ##14 o_service_exit;
	endproperty
	a_mexit_signal: assert property (p_mexit_signal) else $error("service exit pulse late");

	property p_nexit_restore;
		(state == RIR_RUN && kind == K_NEXIT && tcnt == 4'hE) |=>
			(active_irq_enable == $past(saved_irq_enable));
	endproperty
	a_nexit_restore: assert property (p_nexit_restore) else $error("enable not restored");

	property p_nmi_entry;
		(state == RIR_RUN && kind == K_NMI && tcnt == 4'hB) |=>
			(program_counter == 16'h0066 && stack_pointer == entry_sp - 16'h2);
	endproperty
	a_nmi_entry: assert property (p_nmi_entry) else $error("nmi entry wrong");

	property p_flags_kept;
		(state == RIR_RUN) |=> $stable(flags);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

	property p_retcc_len;
		(state == RIR_RUN && kind == K_RETCC && tcnt == 4'h2) |->
			(state == RIR_RUN)[*8] ##1 (state == RIR_RUN)[*2] ##1 (state == RIR_IDLE);
	endproperty
	a_retcc_len: assert property (p_retcc_len) else $error("taken return length wrong");

	c_retcc: cover property (state == RIR_RUN && kind == K_RETCC && tcnt == 4'hB);
	c_skip:  cover property (state == RIR_RUN && kind == K_SKIP && tcnt == 4'h5);
	c_nexit: cover property (state == RIR_RUN && kind == K_NEXIT && tcnt == 4'hE);
	c_nmi:   cover property (state == RIR_RUN && kind == K_NMI && tcnt == 4'hB);

endmodule : rir_core
`default_nettype wire

// ### test/rir_stack_model.sv
// stack memory and two-peripheral priority chain facing the return unit
`timescale 1ns/1ns
`default_nettype none

module rir_stack_model import rir_pkg::*; (
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	input  wire rir_mem_req_t i_mem,
	output logic [7:0]        o_rdata,
	input  wire logic         i_service_exit,
	input  wire logic [1:0]   i_ack,
	output logic [1:0]        o_chain_out
);
	logic [7:0] mem [0:65535];
	logic [7:0] rdata = 8'hA5;
	logic [1:0] served;
	logic [1:0] next_served;

	// ----------------------------------------
	// memory: read data one cycle after the strobe, toggling otherwise
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		if (i_mem.rd) begin
			rdata <= mem[i_mem.addr];
		end else begin
			rdata <= ~rdata;
		end
		if (i_mem.wr) begin
			mem[i_mem.addr] <= i_mem.wdata;
		end
	end
	assign o_rdata = rdata;

	// ----------------------------------------
	// priority chain: bit 1 is the higher-priority peripheral
	// ----------------------------------------
	always_comb begin
		next_served = served;
		if (i_service_exit) begin
			next_served = served[1] ? {1'h0, served[0]} : 2'h0;
		end
		if (i_ack[1]) begin
			next_served[1] = 1'h1;
		end
		if (i_ack[0] && o_chain_out[1]) begin
			next_served[0] = 1'h1;
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			served <= 2'h0;
		end else begin
			served <= next_served;
		end
	end
	assign o_chain_out = {~served[1], ~served[1] & ~served[0]};

endmodule : rir_stack_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench of the return instruction unit
`timescale 1ns/1ns
`default_nettype none
`include "rir_cfg.svh"

module tb_top import rir_pkg::*; ;
	logic         clk, rstn, psel, pen, pwr, pready, pslverr, op_valid, op_ready, nmi;
	logic         svc_exit, irq_en;
	logic [7:0]   paddr, mrd;
	logic [31:0]  pwdata, prdata;
	logic [15:0]  pc;
	logic [1:0]   ack, chain;
	rir_op_t      op;
	rir_mem_req_t mem;
	int           num_errors, comparisons;

	rir_core i_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_op_valid(op_valid), .i_op(op),
		.o_op_ready(op_ready), .i_nmi(nmi), .o_mem(mem), .i_mem_rdata(mrd),
		.o_service_exit(svc_exit), .o_pc(pc), .o_active_irq_enable(irq_en));
	rir_stack_model i_stack (.i_sys_clk(clk), .i_resetn(rstn), .i_mem(mem), .o_rdata(mrd),
		.i_service_exit(svc_exit), .i_ack(ack), .o_chain_out(chain));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic hang(input string nm);
		num_errors++;
		$display("CHECK FAILED %s expected answer seen timeout", nm);
		finish_test();
	endtask : hang

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) hang("apb ready");
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
	endtask : wreg

	task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] exp,
			input logic eexp);
		logic [31:0] r;
		logic        e;
		apb(1'h0, a, 32'h0, r, e);
		chk(nm, exp, r);
		chk({nm, " slverr"}, {31'h0, eexp}, {31'h0, e});
	endtask : rreg

	task automatic wait_rdy(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (op_ready !== 1'h1 && n < 50);
		if (op_ready !== 1'h1) hang("op ready");
	endtask : wait_rdy

	// offers one op and checks the cycles until the unit is ready again
	task automatic issue(input logic [15:0] o, input int len);
		int n;
		@(posedge clk);
		op_valid <= 1'h1;
		op <= o;
		wait_rdy(n);
		op_valid <= 1'h0;
		wait_rdy(n);
		chk("op length", len, n);
		@(negedge clk);
	endtask : issue

	task automatic pulse_ack(input logic [1:0] v);
		@(posedge clk);
		ack <= v;
		@(posedge clk);
		ack <= 2'h0;
		@(posedge clk);
	endtask : pulse_ack

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rreg("status", `RIR_OFS_STATUS, 32'h0, 1'h0);
		rreg("pc", `RIR_OFS_PC, 32'h0, 1'h0);
		rreg("sp", `RIR_OFS_SP, 32'h0, 1'h0);
		rreg("flags", `RIR_OFS_FLAGS, 32'h0, 1'h0);
		rreg("unmapped", 8'h10, 32'h0, 1'h1);
		issue(16'h0000, 4);
		chk("pc", 32'h1, {16'h0, pc});
		issue(16'hED00, 4);
		chk("pc", 32'h3, {16'h0, pc});
		rreg("status", `RIR_OFS_STATUS, 32'h8, 1'h0);
		wreg(`RIR_OFS_STATUS, 32'h8);
		rreg("status", `RIR_OFS_STATUS, 32'h0, 1'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_cond;
		int         pos[8] = '{6, 6, 0, 0, 2, 2, 7, 7};
		logic [7:0] fl;
		i_stack.mem[16'h2000] = 8'hB5;
		i_stack.mem[16'h2001] = 8'h18;
		for (int c = 0; c < 8; c++) begin
			for (int t = 0; t < 2; t++) begin
				fl = 8'h28;
				fl[pos[c]] = c[0] ^ t[0];
				wreg(`RIR_OFS_FLAGS, {24'h0, fl});
				wreg(`RIR_OFS_SP, 32'h2000);
				wreg(`RIR_OFS_PC, 32'h3535);
				issue({2'h3, c[2:0], 3'h0, 8'h00}, t ? 5 : 11);
				chk("pc", t ? 32'h3536 : 32'h18B5, {16'h0, pc});
				rreg("sp", `RIR_OFS_SP, t ? 32'h2000 : 32'h2002, 1'h0);
				rreg("flags", `RIR_OFS_FLAGS, {24'h0, fl}, 1'h0);
			end
		end
		$display("test conditional return done");
	endtask : t_cond

	task automatic t_nmi;
		int n;
		wreg(`RIR_OFS_STATUS, 32'h1);
		wreg(`RIR_OFS_SP, 32'h1000);
		wreg(`RIR_OFS_PC, 32'h1A45);
		@(posedge clk);
		nmi <= 1'h1;
		@(posedge clk);
		nmi <= 1'h0;
		repeat (2) @(posedge clk);
		wait_rdy(n);
		@(negedge clk);
		chk("stack high", 32'h1A, {24'h0, i_stack.mem[16'h0FFF]});
		chk("stack low", 32'h45, {24'h0, i_stack.mem[16'h0FFE]});
		chk("pc", 32'h0066, {16'h0, pc});
		rreg("sp", `RIR_OFS_SP, 32'h0FFE, 1'h0);
		rreg("status", `RIR_OFS_STATUS, 32'h2, 1'h0);
		issue(16'hED45, 14);
		chk("pc", 32'h1A45, {16'h0, pc});
		rreg("sp", `RIR_OFS_SP, 32'h1000, 1'h0);
		chk("irq enable", 32'h1, {31'h0, irq_en});
		$display("test nmi done");
	endtask : t_nmi

	task automatic t_maskable_service_exit;
		wreg(`RIR_OFS_STATUS, 32'h2);
		i_stack.mem[16'h3000] = 8'h34;
		i_stack.mem[16'h3001] = 8'h12;
		i_stack.mem[16'h3002] = 8'h78;
		i_stack.mem[16'h3003] = 8'h56;
		wreg(`RIR_OFS_SP, 32'h3000);
		pulse_ack(2'h1);
		chk("chain", 32'h2, {30'h0, chain});
		pulse_ack(2'h2);
		chk("chain", 32'h0, {30'h0, chain});
		issue(16'hED4D, 14);
		chk("pc", 32'h1234, {16'h0, pc});
		chk("chain", 32'h2, {30'h0, chain});
		chk("irq enable", 32'h0, {31'h0, irq_en});
		wreg(`RIR_OFS_STATUS, 32'h1);
		issue(16'hED4D, 14);
		chk("pc", 32'h5678, {16'h0, pc});
		chk("chain", 32'h3, {30'h0, chain});
		chk("irq enable", 32'h1, {31'h0, irq_en});
		rreg("sp", `RIR_OFS_SP, 32'h3004, 1'h0);
		$display("test maskable exit done");
	endtask : t_maskable_service_exit

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		{rstn, psel, pen, pwr, op_valid, nmi} = 6'h0;
		{paddr, pwdata, op, ack} = '0;
		num_errors = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		repeat (2) @(posedge clk);
		t_reset();
		t_cond();
		t_nmi();
		t_maskable_service_exit();
		finish_test();
	end

endmodule : tb_top
`default_nettype wire
